// ===== ewif_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module ewif_cpu_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_req,
  output logic [3:0] o_seen
);
  // sticky record of accepted sources; vectoring itself is not modelled
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_seen <= 4'h0;
    end else begin
      o_seen <= o_seen | i_req;
    end
  end
endmodule
`default_nettype wire

// ===== ewif_flags.sv
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module ewif_flags (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_ext_int0_pin,
  input wire logic i_ext_int3_pin,
  input wire logic [5:0] i_wake_pin,
  input wire logic i_sleep_direct_xfer,
  output logic o_ext_int0_req,
  output logic o_ext_int3_req,
  output logic o_direct_transition_req,
  output logic o_wake_req,
  output logic o_irq
);
  // true when the selected edge is seen between prev and cur
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic sel);
    edge_hit = sel ? (!prev && cur) : (prev && !cur);
  endfunction

  // write strobe aimed at one register address
  function automatic logic wr_hit(input logic wr, input logic [3:0] addr,
                                  input logic [3:0] a);
    wr_hit = wr && (addr == a);
  endfunction

  // byte of clear mask: bit high where a write puts 0 at this address;
  // bus signals come in as arguments so a continuous assign sees them
  function automatic logic [7:0] clr_mask(input logic wr,
                                          input logic [3:0] addr,
                                          input logic [7:0] wdata,
                                          input logic [3:0] a);
    clr_mask = wr_hit(wr, addr, a) ? ~wdata : ewif_pkg::RST_ZERO;
  endfunction

  // pins are asynchronous: two stages, then a third for edge history
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic [7:0] pin_prev;
  logic [7:0] pin_raw;
  assign pin_raw = {i_ext_int3_pin, i_ext_int0_pin, i_wake_pin};

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_s1 <= 8'hff;
      pin_s2 <= 8'hff;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  // history resets high too, so idle-high pins show no edge at release
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_prev <= 8'hff;
    end else begin
      pin_prev <= pin_s2;
    end
  end

  // software settings
  logic ext_int0_edge_sel;
  logic ext_int3_edge_sel;
  logic [5:0] wake_edge_sel;
  logic direct_transition_enable;
  logic wake_common_enable;
  logic ext_int3_enable;
  logic ext_int0_enable;
  logic ext_int0_func;
  logic ext_int3_func;
  logic [5:0] wake_func;
  logic direct_transfer_enable;
  logic [3:0] evt_mask;

  // one block per register keeps a decode slip local to that register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_int0_edge_sel <= 1'b0;
      ext_int3_edge_sel <= 1'b0;
    end else if (wr_hit(i_wr, i_addr, ewif_pkg::ADDR_EXT_EDGE)) begin
      ext_int0_edge_sel <= i_wdata[ewif_pkg::BIT_EXT0];
      ext_int3_edge_sel <= i_wdata[ewif_pkg::BIT_EXT3];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wake_edge_sel <= 6'h00;
    end else if (wr_hit(i_wr, i_addr, ewif_pkg::ADDR_WAKE_EDGE)) begin
      wake_edge_sel <= i_wdata[5:0];
    end
  end

  // enables gate only the cpu requests; flags keep latching regardless
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      direct_transition_enable <= 1'b0;
      wake_common_enable <= 1'b0;
      ext_int3_enable <= 1'b0;
      ext_int0_enable <= 1'b0;
    end else if (wr_hit(i_wr, i_addr, ewif_pkg::ADDR_ENABLE)) begin
      direct_transition_enable <= i_wdata[ewif_pkg::BIT_DT];
      wake_common_enable <= i_wdata[ewif_pkg::BIT_WAKE_EN];
      ext_int3_enable <= i_wdata[ewif_pkg::BIT_EXT3];
      ext_int0_enable <= i_wdata[ewif_pkg::BIT_EXT0];
    end
  end

  // function off means edges are dropped, not held for later
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_int0_func <= 1'b0;
      ext_int3_func <= 1'b0;
    end else if (wr_hit(i_wr, i_addr, ewif_pkg::ADDR_EXT_FUNC)) begin
      ext_int0_func <= i_wdata[ewif_pkg::BIT_EXT0];
      ext_int3_func <= i_wdata[ewif_pkg::BIT_EXT3];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wake_func <= 6'h00;
    end else if (wr_hit(i_wr, i_addr, ewif_pkg::ADDR_WAKE_FUNC)) begin
      wake_func <= i_wdata[5:0];
    end
  end

  // the sleep logic raises its strobe anyway; this bit decides if it counts
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      direct_transfer_enable <= 1'b0;
    end else if (wr_hit(i_wr, i_addr, ewif_pkg::ADDR_SYS_CTRL)) begin
      direct_transfer_enable <= i_wdata[ewif_pkg::BIT_DT_XFER_EN];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_mask <= 4'h0;
    end else if (wr_hit(i_wr, i_addr, ewif_pkg::ADDR_EVT_MASK)) begin
      evt_mask <= i_wdata[3:0];
    end
  end

  // set events; a pin not in interrupt function never sets its flag
  logic set_ext0;
  logic set_ext3;
  logic set_dt;
  logic [5:0] set_wake;
  assign set_ext0 = ext_int0_func && edge_hit(pin_prev[6], pin_s2[6],
                    ext_int0_edge_sel);
  assign set_ext3 = ext_int3_func && edge_hit(pin_prev[7], pin_s2[7],
                    ext_int3_edge_sel);
  assign set_dt = i_sleep_direct_xfer && direct_transfer_enable;

  genvar g;
  generate
    for (g = 0; g < ewif_pkg::NUM_WAKE; g++) begin : g_wake
      assign set_wake[g] = wake_func[g] &&
        edge_hit(pin_prev[g], pin_s2[g], wake_edge_sel[g]);
    end
  endgenerate

  // request flags
  logic ext_int0_req_flag;
  logic ext_int3_req_flag;
  logic direct_transition_req_flag;
  logic [5:0] wake_req_flag;
  logic [7:0] irq_clr;
  logic [7:0] wake_clr;
  assign irq_clr = clr_mask(i_wr, i_addr, i_wdata,
                            ewif_pkg::ADDR_IRQ_FLAGS);
  assign wake_clr = clr_mask(i_wr, i_addr, i_wdata,
                             ewif_pkg::ADDR_WAKE_FLAGS);

  // writing 1 leaves a flag alone; a set in the clear cycle survives
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_int0_req_flag <= 1'b0;
    end else begin
      ext_int0_req_flag <= set_ext0 || (ext_int0_req_flag &&
        !irq_clr[ewif_pkg::BIT_EXT0]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_int3_req_flag <= 1'b0;
    end else begin
      ext_int3_req_flag <= set_ext3 || (ext_int3_req_flag &&
        !irq_clr[ewif_pkg::BIT_EXT3]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      direct_transition_req_flag <= 1'b0;
    end else begin
      direct_transition_req_flag <= set_dt || (direct_transition_req_flag
        && !irq_clr[ewif_pkg::BIT_DT]);
    end
  end

  // each wake bit clears on its own, so one write can keep the others
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wake_req_flag <= 6'h00;
    end else begin
      wake_req_flag <= set_wake | (wake_req_flag & ~wake_clr[5:0]);
    end
  end

  // requests to the cpu, gated by enables; one cycle behind the flags
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ext_int0_req <= 1'b0;
    end else begin
      o_ext_int0_req <= ext_int0_req_flag && ext_int0_enable;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ext_int3_req <= 1'b0;
    end else begin
      o_ext_int3_req <= ext_int3_req_flag && ext_int3_enable;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_direct_transition_req <= 1'b0;
    end else begin
      o_direct_transition_req <= direct_transition_req_flag &&
        direct_transition_enable;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_wake_req <= 1'b0;
    end else begin
      // one shared vector for all six wake sources
      o_wake_req <= (|wake_req_flag) && wake_common_enable;
    end
  end

  // sticky event status, write one to clear, set wins
  logic [3:0] evt_status;
  logic [3:0] evt_set;
  logic [3:0] evt_clr;
  logic [3:0] next_evt_status;
  assign evt_set = {|set_wake, set_dt, set_ext3, set_ext0};
  assign evt_clr = (i_wr && i_addr == ewif_pkg::ADDR_EVT_STATUS) ?
                   i_wdata[3:0] : 4'h0;
  assign next_evt_status = evt_set | (evt_status & ~evt_clr);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      evt_status <= 4'h0;
    end else begin
      evt_status <= next_evt_status;
    end
  end

  // taken from the next status so o_irq rises with the status bit
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(next_evt_status & evt_mask);
    end
  end

  // read data stands one cycle, zero otherwise and for unmapped addresses
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = ewif_pkg::RST_ZERO;
    if (i_rd) begin
      case (i_addr)
        ewif_pkg::ADDR_IRQ_FLAGS: begin
          // bits 6, 2 and 1 stay zero, bits 5 and 4 stay one
          next_rdata = ewif_pkg::IRQ_FLAGS_ONES;
          next_rdata[ewif_pkg::BIT_DT] = direct_transition_req_flag;
          next_rdata[ewif_pkg::BIT_EXT3] = ext_int3_req_flag;
          next_rdata[ewif_pkg::BIT_EXT0] = ext_int0_req_flag;
        end
        ewif_pkg::ADDR_WAKE_FLAGS: begin
          next_rdata = ewif_pkg::WAKE_FLAGS_ONES | {2'b00, wake_req_flag};
        end
        ewif_pkg::ADDR_EXT_EDGE: begin
          next_rdata = ewif_pkg::EXT_EDGE_ONES;
          next_rdata[ewif_pkg::BIT_EXT3] = ext_int3_edge_sel;
          next_rdata[ewif_pkg::BIT_EXT0] = ext_int0_edge_sel;
        end
        ewif_pkg::ADDR_WAKE_EDGE: begin
          next_rdata = ewif_pkg::WAKE_EDGE_ONES | {2'b00, wake_edge_sel};
        end
        ewif_pkg::ADDR_ENABLE: begin
          next_rdata = ewif_pkg::ENABLE_ONES;
          next_rdata[ewif_pkg::BIT_DT] = direct_transition_enable;
          next_rdata[ewif_pkg::BIT_WAKE_EN] = wake_common_enable;
          next_rdata[ewif_pkg::BIT_EXT3] = ext_int3_enable;
          next_rdata[ewif_pkg::BIT_EXT0] = ext_int0_enable;
        end
        ewif_pkg::ADDR_EXT_FUNC: begin
          next_rdata[ewif_pkg::BIT_EXT3] = ext_int3_func;
          next_rdata[ewif_pkg::BIT_EXT0] = ext_int0_func;
        end
        ewif_pkg::ADDR_WAKE_FUNC: begin
          next_rdata = {2'b00, wake_func};
        end
        ewif_pkg::ADDR_SYS_CTRL: begin
          next_rdata[ewif_pkg::BIT_DT_XFER_EN] = direct_transfer_enable;
        end
        ewif_pkg::ADDR_EVT_STATUS: begin
          next_rdata = {4'h0, evt_status};
        end
        ewif_pkg::ADDR_EVT_MASK: begin
          next_rdata = {4'h0, evt_mask};
        end
        default: begin
          next_rdata = ewif_pkg::RST_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= ewif_pkg::RST_ZERO;
    end else begin
      o_rdata <= next_rdata;
    end
  end
endmodule
`default_nettype wire

// ===== ewif_flags_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ewif_flags_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_ext_int0_pin,
  input wire logic i_ext_int3_pin,
  input wire logic [5:0] i_wake_pin,
  input wire logic i_sleep_direct_xfer,
  input wire logic o_ext_int0_req,
  input wire logic o_ext_int3_req,
  input wire logic o_direct_transition_req,
  input wire logic o_wake_req,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  flag_resv_a: assert property (
    i_rd && i_addr == 4'h0 |=>
    o_rdata[6:4] == 3'b011 && o_rdata[2:1] == 2'b00) else $error("flag pad");
  wake_resv_a: assert property (i_rd && i_addr == 4'h1 |=>
    o_rdata[7:6] == 2'b11) else $error("wake pad bits");
  // reset must win even though the default disable would hide it
  reset_clear_a: assert property (disable iff (1'b0) i_rst |=>
    !(o_irq | o_wake_req | o_ext_int0_req | o_ext_int3_req |
    o_direct_transition_req)) else $error("outputs up after reset");
  dt_clear_a: assert property (i_wr && i_addr == 4'h0 &&
    !i_wdata[7] && !i_sleep_direct_xfer |=> ##1 !o_direct_transition_req)
    else $error("dt request survived clear");
  dt_cause_a: assert property ($rose(o_direct_transition_req) |->
    $past(i_sleep_direct_xfer, 2) || $past(i_wr, 2))
    else $error("dt request without cause");
  keep_on_one_a: assert property (i_wr && i_addr == 4'h0 &&
    i_wdata[0] ##1 o_ext_int0_req |=> o_ext_int0_req)
    else $error("write one dropped flag");
  wake_off_a: assert property (i_wr && i_addr == 4'h4 && !i_wdata[5]
    |=> ##1 !o_wake_req) else $error("wake request while disabled");
  ext3_off_a: assert property (i_wr && i_addr == 4'h4 && !i_wdata[3]
    |=> ##1 !o_ext_int3_req) else $error("ext3 request while disabled");
endmodule
bind ewif_flags ewif_flags_chk chk (.i_clk, .i_rst, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_ext_int0_pin, .i_ext_int3_pin, .i_wake_pin,
  .i_sleep_direct_xfer, .o_ext_int0_req, .o_ext_int3_req,
  .o_direct_transition_req, .o_wake_req, .o_irq);
`default_nettype wire

// ===== ewif_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ewif_flags_tb;
  logic i_clk, i_rst, i_wr, i_rd, i_ext_int0_pin, i_ext_int3_pin;
  logic i_sleep_direct_xfer, o_ext_int0_req, o_ext_int3_req;
  logic o_direct_transition_req, o_wake_req, o_irq;
  logic [3:0] i_addr, seen;
  logic [7:0] i_wdata, o_rdata;
  logic [5:0] i_wake_pin;
  int failures = 0;
  int compares = 0;
  int n;
  ewif_flags DUT (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_ext_int0_pin, .i_ext_int3_pin, .i_wake_pin, .i_sleep_direct_xfer,
    .o_ext_int0_req, .o_ext_int3_req, .o_direct_transition_req,
    .o_wake_req, .o_irq);
  ewif_cpu_model cpu (.i_clk, .i_rst, .o_seen(seen), .i_req({o_wake_req,
    o_direct_transition_req, o_ext_int3_req, o_ext_int0_req}));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 check(o_rdata, exp);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge i_clk);
    #1;
  endtask
  task automatic sleep_pulse;
    @(posedge i_clk) i_sleep_direct_xfer <= 1'b1;
    @(posedge i_clk) i_sleep_direct_xfer <= 1'b0;
  endtask
  task automatic finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    {i_rst, i_wr, i_rd, i_sleep_direct_xfer} = 4'h8;
    {i_ext_int0_pin, i_ext_int3_pin, i_wake_pin} = 8'hff;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(4'h0, 8'h30);
    rd(4'h1, 8'hc0);
    wr(4'h0, 8'h46);
    rd(4'h0, 8'h30);
    $display("test reset done");
    wr(4'h5, 8'h09);
    wr(4'h4, 8'hff);
    wr(4'h9, 8'h0f);
    @(posedge i_clk) i_ext_int0_pin <= 1'b0;
    idle(5);
    check(o_ext_int0_req, 1'b1);
    check(o_irq, 1'b1);
    rd(4'h0, 8'h31);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'h31);
    wr(4'h0, 8'hfe);
    wr(4'h8, 8'hff);
    rd(4'h0, 8'h30);
    check(o_irq, 1'b0);
    // rising select: the falling edge must pass unseen
    wr(4'h2, 8'h08);
    @(posedge i_clk) i_ext_int3_pin <= 1'b0;
    idle(5);
    rd(4'h0, 8'h30);
    @(posedge i_clk) i_ext_int3_pin <= 1'b1;
    idle(5);
    rd(4'h0, 8'h38);
    check(seen, 4'h3);
    wr(4'h4, 8'ha1);
    idle(2);
    check(o_ext_int3_req, 1'b0);
    wr(4'h0, 8'hf7);
    rd(4'h0, 8'h30);
    $display("test ext done");
    wr(4'h6, 8'h3f);
    for (n = 0; n < 6; n++) begin
      @(posedge i_clk) i_wake_pin[n] <= 1'b0;
      idle(5);
      rd(4'h1, 8'hc0 | ((8'h02 << n) - 8'h01));
    end
    check(o_wake_req, 1'b1);
    wr(4'h1, 8'hfb);
    rd(4'h1, 8'hfb);
    wr(4'h4, 8'h00);
    idle(2);
    check(o_wake_req, 1'b0);
    $display("test wake done");
    sleep_pulse;
    rd(4'h0, 8'h30);
    wr(4'h7, 8'h01);
    wr(4'h4, 8'h80);
    sleep_pulse;
    idle(2);
    check(o_direct_transition_req, 1'b1);
    rd(4'h0, 8'hb0);
    wr(4'h0, 8'h7f);
    rd(4'h0, 8'h30);
    wr(4'h9, 8'h00);
    fork
      wr(4'h0, 8'h7f);
      sleep_pulse;
    join
    rd(4'h0, 8'hb0);
    check(o_irq, 1'b0);
    $display("test direct done");
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(4'h0, 8'h30);
    rd(4'h1, 8'hc0);
    check(o_direct_transition_req, 1'b0);
    check(seen, 4'h0);
    $display("test midrun reset done");
    finish_test;
  end
  initial begin
    #20000;
    failures++;
    finish_test;
  end
endmodule
`default_nettype wire

// ===== ewif_pkg.sv
// Behaviour
// - sleep direct transfer sets bit 7 flag
// - writing 0 clears direct transition flag
// - ext int 3 edge sets bit 3
// - writing 0 clears ext int 3 flag
// - ext int 0 edge sets bit 0
// - writing 0 clears ext int 0 flag
// - six wake pins set bits 5..0
// - writing 0 clears each wake flag
// - flag bit 6 reads 0, writes ignored
// - flag bits 5,4 and wake 7,6 read 1
// - flag bits 2,1 read 0, writes ignored
// - edge select 0 falling, 1 rising
// - wake flags forwarded only with common enable
// - ext and direct flags need own enable
`default_nettype none
package ewif_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] ADDR_IRQ_FLAGS = 4'h0;
  localparam logic [3:0] ADDR_WAKE_FLAGS = 4'h1;
  localparam logic [3:0] ADDR_EXT_EDGE = 4'h2;
  localparam logic [3:0] ADDR_WAKE_EDGE = 4'h3;
  localparam logic [3:0] ADDR_ENABLE = 4'h4;
  localparam logic [3:0] ADDR_EXT_FUNC = 4'h5;
  localparam logic [3:0] ADDR_WAKE_FUNC = 4'h6;
  localparam logic [3:0] ADDR_SYS_CTRL = 4'h7;
  localparam logic [3:0] ADDR_EVT_STATUS = 4'h8;
  localparam logic [3:0] ADDR_EVT_MASK = 4'h9;
  // bit positions in the flag, edge, enable, function and system control registers
  localparam int BIT_DT = 7;
  localparam int BIT_WAKE_EN = 5;
  localparam int BIT_EXT3 = 3;
  localparam int BIT_EXT0 = 0;
  localparam int BIT_DT_XFER_EN = 0;
  localparam int NUM_WAKE = 6;
  // fixed reserved patterns, or-ed into read data
  localparam logic [7:0] IRQ_FLAGS_ONES = 8'h30;
  localparam logic [7:0] WAKE_FLAGS_ONES = 8'hc0;
  localparam logic [7:0] EXT_EDGE_ONES = 8'h70;
  localparam logic [7:0] WAKE_EDGE_ONES = 8'hc0;
  localparam logic [7:0] ENABLE_ONES = 8'h10;
  // event status bits
  localparam int EVT_EXT0 = 0;
  localparam int EVT_EXT3 = 1;
  localparam int EVT_DT = 2;
  localparam int EVT_WAKE = 3;
  localparam int NUM_EVT = 4;
  localparam logic [7:0] RST_ZERO = 8'h00;
endpackage
`default_nettype wire
